// ---- rtl/bsfd_cfg.svh ----
`ifndef BSFD_CFG_SVH
`define BSFD_CFG_SVH

`define BSFD_OFF_ID 8'h00
`define BSFD_OFF_FAULT 8'h01
`define BSFD_OFF_STATUS 8'h02
`define BSFD_OFF_MODE 8'h03
`define BSFD_OFF_SETPOINT 8'h04
`define BSFD_OFF_FLOOR 8'h05
`define BSFD_OFF_CEILING 8'h06
`define BSFD_OFF_SHUTDOWN 8'h07
`define BSFD_OFF_LIMIT 8'h08
`define BSFD_OFF_RESET 8'h09

`define BSFD_MODE_ENABLE 7
`define BSFD_MODE_FORCE 6
`define BSFD_MODE_LOCK 5
`define BSFD_MODE_SS_TO 4
`define BSFD_MODE_RAMP_EN 3
`define BSFD_SHD_DISCHARGE 2

`define BSFD_FLT_STARTUP 4
`define BSFD_FLT_UVLO 3
`define BSFD_FLT_OT 2
`define BSFD_FLT_SHORT 1
`define BSFD_FLT_ILIM 0

`define BSFD_SEL_OPEN 2'h0
`define BSFD_SEL_RST 2'h1
`define BSFD_SETPOINT_RST 8'h6e
`define BSFD_FLOOR_RST 8'h00
`define BSFD_CODE_MAX 8'hb4
`define BSFD_LIMIT_RST 8'hff
`define BSFD_SOFT_RESET_CODE 8'ha5

`define BSFD_CLK_MHZ 100
`define BSFD_STEP_MV 10
`define BSFD_SS_US 520
`define BSFD_SS_STEP_CYC ((`BSFD_SS_US * `BSFD_CLK_MHZ) / 181)
`define BSFD_PD_US 2
`define BSFD_PD_CYC (`BSFD_PD_US * `BSFD_CLK_MHZ)
`define BSFD_ILIM_US 500
`define BSFD_ILIM_CYC (`BSFD_ILIM_US * `BSFD_CLK_MHZ)
`define BSFD_RESTART_MS 20
`define BSFD_RESTART_CYC (`BSFD_RESTART_MS * 1000 * `BSFD_CLK_MHZ)

`endif

// ---- rtl/bsfd_pkg.sv ----
`include "bsfd_cfg.svh"

package bsfd_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SOFT = 2'b01,
      ST_ACT = 2'b11,
      ST_WAIT = 2'b10
   } bsfd_state_t;

   // Rate codes are tenths of a millivolt per microsecond.
   function automatic logic [15:0] bsfd_step_cycles(input logic [2:0] rate);
      int tenths;
      case (rate)
         3'h0: tenths = 5;
         3'h1: tenths = 10;
         3'h2: tenths = 20;
         3'h3: tenths = 25;
         3'h4: tenths = 40;
         3'h5: tenths = 50;
         3'h6: tenths = 80;
         default: tenths = 100;
      endcase
      return 16'((`BSFD_STEP_MV * 10 * `BSFD_CLK_MHZ) / tenths);
   endfunction : bsfd_step_cycles

endpackage : bsfd_pkg

// ---- rtl/bsfd_timer.sv ----
`timescale 1ns/1ns

module bsfd_timer
#(
   parameter int W = 22
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [W-1:0] limit,
   output logic done
);

   logic [W-1:0] cnt_q;

   always_ff @(posedge clk)
   begin
      if (rst || !run)
         cnt_q <= '0;
      else if (cnt_q != limit)
         cnt_q <= cnt_q + 1'b1;
   end

   assign done = run && (cnt_q == limit);

endmodule : bsfd_timer

// ---- rtl/bsfd_ramp.sv ----
`timescale 1ns/1ns

module bsfd_ramp
#(
   parameter int CODE_W = 8,
   parameter int CNT_W = 16
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hold_zero,
   input wire logic [CODE_W-1:0] target,
   input wire logic [CNT_W-1:0] interval,
   input wire logic jump_down,
   output logic [CODE_W-1:0] code,
   output logic down_busy
);

   logic [CNT_W-1:0] cnt_q;
   logic tick;

   assign tick = (cnt_q + 1'b1) >= interval;
   assign down_busy = code > target;

   // Every move is one code per interval; only a plain downward change
   // may jump straight to the target.
   always_ff @(posedge clk)
   begin
      if (rst || hold_zero)
      begin
         code <= '0;
         cnt_q <= '0;
      end
      else if (down_busy && jump_down)
      begin
         code <= target;
         cnt_q <= '0;
      end
      else if (code != target)
      begin
         if (tick)
         begin
            cnt_q <= '0;
            code <= down_busy ? code - 1'b1 : code + 1'b1;
         end
         else
            cnt_q <= cnt_q + 1'b1;
      end
      else
         cnt_q <= '0;
   end

endmodule : bsfd_ramp

// ---- rtl/bsfd_top.sv ----
// Operation
// (RULE1) Input undervoltage while running clears enable, idles.
// (RULE2) Overtemperature clears enable; stays idle until re-enabled.
// (RULE3) Events set live status and read-cleared fault bits.
// (RULE4) Enable starts soft-start ramp to target.
// (RULE5) Disable tristates output; nonzero select discharges.
// (RULE6) Pulldown engages about 2 us after disable.
// (RULE7) Pulldown select: 50, 100, 200 ohm, open.
// (RULE8) Discharge bit pulls down during downward steps.
// (RULE9) Auto light-load mode; force bit holds fixed-frequency.
// (RULE10) Bypass entered automatically when input nears output.
// (RULE11) Output below half sets short fault at once.
// (RULE12) Light-load limit 500-1325 mA; lock freezes limits.
// (RULE13) 500 us limiting: fault, 20 ms off, retry.
// (RULE14) Fixed-frequency limit 440-2090 mA in 110 mA.
// (RULE15) Enable with input below rising threshold is refused.
// (RULE16) Fault shutdown resets bypass 0, light-load 1.
// (RULE17) Fixed mode reverse current tristates until output falls.
// (RULE18) Light-load mode tristates when output forced high.
// (RULE19) Setpoint 1.5-3.3 V, DAC stepped code by code.
// (RULE20) Setpoint outside floor or ceiling is clamped.
// (RULE21) New floor or ceiling waits for next setpoint.
// (RULE22) Ramp rate 0.5-10 mV/us; ramp bit steps down.
// (RULE23) Ramp bit alone starts no transition.
// (RULE24) Enable during a present fault is cleared at once.
// (RULE25) Step interval timed from ramp rate locally.
`timescale 1ns/1ns
`include "bsfd_cfg.svh"

module bsfd_top
   import bsfd_pkg::*;
#(
   parameter int ILIM_CYC = `BSFD_ILIM_CYC,
   parameter int RESTART_CYC = `BSFD_RESTART_CYC,
   // Identity values are arbitrary.
   parameter logic [3:0] PRODUCT_ID = 4'h5,
   parameter logic [3:0] SILICON_REV = 4'h2
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [7:0] reg_rdata,
   input wire logic vin_above_rise,
   input wire logic vin_below_fall,
   input wire logic over_temp,
   input wire logic vout_below_half,
   input wire logic ilim_hit,
   input wire logic ineg_hit,
   input wire logic vout_above_target,
   input wire logic vin_near_vout,
   input wire logic load_below_light,
   input wire logic load_above_heavy,
   output logic conv_en,
   output logic soft_start,
   output logic out_tristate,
   output logic pulse_freq_mode,
   output logic bypass_on,
   output logic pulldown_on,
   output logic [1:0] pulldown_sel,
   output logic [7:0] dac_code,
   output logic [3:0] light_limit_code,
   output logic [3:0] fixed_limit_code
);

   localparam int TW = 22;

   if (ILIM_CYC < 1 || ILIM_CYC >= (1 << TW)) begin : g_bad_ilim
      $error("ILIM_CYC out of range");
   end
   if (RESTART_CYC < 1 || RESTART_CYC >= (1 << TW)) begin : g_bad_rst
      $error("RESTART_CYC out of range");
   end

   logic [9:0] sync1_q;
   logic [9:0] sync2_q;
   logic ot_prev_q;
   logic vin_ok, vin_fall, ot, below_half, ilim, ineg, above_tgt;
   logic near, light, heavy;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
         ot_prev_q <= 1'b0;
      end
      else
      begin
         sync1_q <= {vin_above_rise, vin_below_fall, over_temp,
                     vout_below_half, ilim_hit, ineg_hit,
                     vout_above_target, vin_near_vout,
                     load_below_light, load_above_heavy};
         sync2_q <= sync1_q;
         ot_prev_q <= sync2_q[7];
      end
   end

   assign vin_ok = sync2_q[9];
   assign vin_fall = sync2_q[8];
   assign ot = sync2_q[7];
   assign below_half = sync2_q[6];
   assign ilim = sync2_q[5];
   assign ineg = sync2_q[4];
   assign above_tgt = sync2_q[3];
   assign near = sync2_q[2];
   assign light = sync2_q[1];
   assign heavy = sync2_q[0];

   // A register reset runs through the same path as the reset pin, except for the input synchronizers.
   logic soft_rst_q;
   logic srst;
   assign srst = rst || soft_rst_q;

   logic wr_mode, wr_set, wr_floor, wr_ceil, wr_shd, wr_lim, rd_fault;
   assign wr_mode = reg_we && reg_addr == `BSFD_OFF_MODE;
   assign wr_set = reg_we && reg_addr == `BSFD_OFF_SETPOINT;
   assign wr_floor = reg_we && reg_addr == `BSFD_OFF_FLOOR;
   assign wr_ceil = reg_we && reg_addr == `BSFD_OFF_CEILING;
   assign wr_shd = reg_we && reg_addr == `BSFD_OFF_SHUTDOWN;
   assign wr_lim = reg_we && reg_addr == `BSFD_OFF_LIMIT;
   assign rd_fault = reg_re && reg_addr == `BSFD_OFF_FAULT;

   always_ff @(posedge clk)
   begin
      if (rst)
         soft_rst_q <= 1'b0;
      else
         soft_rst_q <= reg_we && reg_addr == `BSFD_OFF_RESET &&
                       reg_wdata == `BSFD_SOFT_RESET_CODE;
   end

   bsfd_state_t state_q;
   logic enable_q, force_q, lock_q, ss_to_q, ramp_en_q;
   logic [2:0] rate_q;
   logic running, kill, refuse, ilim_done, restart_done, pd_done;
   logic retry_q;
   logic [7:0] ramp_code;
   logic ramp_down;
   logic [7:0] target_q;

   assign running = state_q != ST_IDLE;
   assign kill = running && (vin_fall || ot); // see (RULE1) (RULE2)
   assign refuse = !vin_ok || ot; // see (RULE15) (RULE24)

   // A shutdown from the analog side wins over a write in the same cycle.
   always_ff @(posedge clk)
   begin
      if (srst)
         enable_q <= 1'b0;
      else if (kill)
         enable_q <= 1'b0; // see (RULE1) (RULE2)
      else if (wr_mode)
         enable_q <= reg_wdata[`BSFD_MODE_ENABLE] && !refuse; // see (RULE24)
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         force_q <= 1'b0;
         lock_q <= 1'b0;
         ss_to_q <= 1'b0;
         ramp_en_q <= 1'b0;
         rate_q <= 3'h0;
      end
      else if (wr_mode)
      begin
         force_q <= reg_wdata[`BSFD_MODE_FORCE];
         lock_q <= lock_q || reg_wdata[`BSFD_MODE_LOCK]; // see (RULE12)
         ss_to_q <= reg_wdata[`BSFD_MODE_SS_TO];
         ramp_en_q <= reg_wdata[`BSFD_MODE_RAMP_EN];
         rate_q <= reg_wdata[2:0]; // see (RULE22)
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         state_q <= ST_IDLE;
      else
      begin
         case (state_q)
            ST_IDLE:
               if (enable_q)
                  state_q <= ST_SOFT; // see (RULE4)
            ST_SOFT:
               if (kill || !enable_q)
                  state_q <= ST_IDLE;
               else if (ramp_code == target_q)
                  state_q <= ST_ACT;
            ST_ACT:
               if (kill || !enable_q)
                  state_q <= ST_IDLE;
               else if (ilim_done)
                  state_q <= ST_WAIT; // see (RULE13)
            ST_WAIT:
               if (kill || !enable_q)
                  state_q <= ST_IDLE;
               else if (restart_done)
                  state_q <= ST_SOFT; // see (RULE13)
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // The retry mark tells a repeated trip after a restart from a first one.
   always_ff @(posedge clk)
   begin
      if (srst || state_q == ST_IDLE)
         retry_q <= 1'b0;
      else if (ilim_done)
         retry_q <= 1'b1;
   end

   bsfd_timer #(.W(TW)) u_ilim_timer (
      .clk(clk),
      .rst(srst),
      .run(state_q == ST_ACT && ilim),
      .limit(TW'(ILIM_CYC)),
      .done(ilim_done)
   );

   bsfd_timer #(.W(TW)) u_restart_timer (
      .clk(clk),
      .rst(srst),
      .run(state_q == ST_WAIT),
      .limit(TW'(RESTART_CYC)),
      .done(restart_done)
   );

   bsfd_timer #(.W(TW)) u_pd_timer (
      .clk(clk),
      .rst(srst),
      .run(!enable_q && state_q == ST_IDLE),
      .limit(TW'(`BSFD_PD_CYC)),
      .done(pd_done)
   );

   logic [7:0] floor_q, ceil_q, set_q, lim_q;
   logic [2:0] shd_q;
   logic [7:0] set_cap;

   assign set_cap = reg_wdata > `BSFD_CODE_MAX ? `BSFD_CODE_MAX : reg_wdata;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         set_q <= `BSFD_SETPOINT_RST;
         target_q <= `BSFD_SETPOINT_RST;
      end
      else if (wr_set)
      begin
         set_q <= set_cap; // see (RULE19)
         if (set_cap > ceil_q)
            target_q <= ceil_q; // see (RULE20)
         else if (set_cap < floor_q)
            target_q <= floor_q; // see (RULE20)
         else
            target_q <= set_cap;
      end
   end

   // Floor and ceiling only act at the next setpoint write; the limit register acts at once.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         floor_q <= `BSFD_FLOOR_RST;
         ceil_q <= `BSFD_CODE_MAX;
         lim_q <= `BSFD_LIMIT_RST;
      end
      else
      begin
         if (wr_floor && !lock_q)
            floor_q <= set_cap; // see (RULE21)
         if (wr_ceil && !lock_q)
            ceil_q <= set_cap; // see (RULE21)
         if (wr_lim && !lock_q)
            lim_q <= reg_wdata; // see (RULE12) (RULE14)
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         shd_q <= {1'b0, `BSFD_SEL_RST}; // see (RULE7)
      else if (wr_shd)
         shd_q <= reg_wdata[2:0];
   end

   bsfd_ramp #(.CODE_W(8), .CNT_W(16)) u_ramp (
      .clk(clk),
      .rst(srst),
      .hold_zero(!(state_q == ST_SOFT || state_q == ST_ACT)),
      .target(target_q),
      .interval(state_q == ST_SOFT ? 16'(`BSFD_SS_STEP_CYC) :
                bsfd_step_cycles(rate_q)), // see (RULE25) (RULE4)
      .jump_down(!ramp_en_q), // see (RULE22) (RULE23)
      .code(ramp_code),
      .down_busy(ramp_down)
   );

   logic [4:0] fault_q;
   logic [4:0] fault_set;
   logic uvlo_evt, uvlo_stat_q;

   assign uvlo_evt = (running && vin_fall) ||
                     (wr_mode && reg_wdata[`BSFD_MODE_ENABLE] &&
                      !vin_ok); // see (RULE15)

   always_comb
   begin
      fault_set = '0;
      fault_set[`BSFD_FLT_UVLO] = uvlo_evt;
      fault_set[`BSFD_FLT_OT] = ot && !ot_prev_q;
      fault_set[`BSFD_FLT_SHORT] = (state_q == ST_ACT && below_half) ||
                                   (ilim_done && retry_q); // see (RULE11)
      fault_set[`BSFD_FLT_ILIM] = ilim_done; // see (RULE13)
      fault_set[`BSFD_FLT_STARTUP] = state_q == ST_SOFT && ss_to_q &&
                                     ramp_code == target_q && below_half;
   end

   // Set wins over the read clear, so no event is lost.
   always_ff @(posedge clk)
   begin
      if (srst)
         fault_q <= '0;
      else if (rd_fault)
         fault_q <= fault_set; // see (RULE3)
      else
         fault_q <= fault_q | fault_set; // see (RULE3)
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         uvlo_stat_q <= 1'b0;
      else if (uvlo_evt)
         uvlo_stat_q <= 1'b1; // see (RULE3)
      else if (vin_ok)
         uvlo_stat_q <= 1'b0;
   end

   logic pfm_q, bypass_q, negtri_q;

   always_ff @(posedge clk)
   begin
      if (srst || kill || state_q == ST_IDLE)
         pfm_q <= 1'b1; // see (RULE16)
      else if (force_q)
         pfm_q <= 1'b0; // see (RULE9)
      else if (heavy)
         pfm_q <= 1'b0; // see (RULE9)
      else if (light)
         pfm_q <= 1'b1; // see (RULE9)
   end

   always_ff @(posedge clk)
   begin
      if (srst || kill)
         bypass_q <= 1'b0; // see (RULE16)
      else
         bypass_q <= state_q == ST_ACT && near; // see (RULE10)
   end

   // Reverse-current hold releases when the forced output drops, or on leaving ST_ACT or fixed-frequency mode.
   always_ff @(posedge clk)
   begin
      if (srst || state_q != ST_ACT || pfm_q)
         negtri_q <= 1'b0;
      else if (ineg)
         negtri_q <= 1'b1; // see (RULE17)
      else if (!above_tgt)
         negtri_q <= 1'b0; // see (RULE17)
   end

   logic [6:0] status;
   assign status = {state_q == ST_IDLE || state_q == ST_ACT ?
                    !(uvlo_stat_q || ot) : 1'b0,
                    bypass_q, pfm_q, uvlo_stat_q, ot,
                    state_q == ST_ACT && below_half,
                    conv_en && ilim};

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         conv_en <= 1'b0;
         soft_start <= 1'b0;
         out_tristate <= 1'b1;
         pulldown_on <= 1'b0;
      end
      else
      begin
         conv_en <= state_q == ST_SOFT || state_q == ST_ACT;
         soft_start <= state_q == ST_SOFT;
         out_tristate <= !(state_q == ST_SOFT || state_q == ST_ACT) ||
                         negtri_q ||
                         (pfm_q && above_tgt); // see (RULE5) (RULE18)
         pulldown_on <= shd_q[1:0] != `BSFD_SEL_OPEN &&
                        (pd_done || // see (RULE5) (RULE6)
                         (shd_q[`BSFD_SHD_DISCHARGE] && ramp_down &&
                          state_q == ST_ACT)); // see (RULE8)
      end
   end

   assign pulse_freq_mode = pfm_q;
   assign bypass_on = bypass_q;
   assign pulldown_sel = shd_q[1:0]; // see (RULE7)
   assign dac_code = ramp_code;
   assign light_limit_code = lim_q[7:4];
   assign fixed_limit_code = lim_q[3:0];

   always_ff @(posedge clk)
   begin
      if (srst)
         reg_rdata <= '0;
      else if (reg_re)
      begin
         case (reg_addr)
            `BSFD_OFF_ID: reg_rdata <= {PRODUCT_ID, SILICON_REV};
            `BSFD_OFF_FAULT: reg_rdata <= {3'h0, fault_q};
            `BSFD_OFF_STATUS: reg_rdata <= {1'b0, status};
            `BSFD_OFF_MODE: reg_rdata <= {enable_q, force_q, lock_q,
                                         ss_to_q, ramp_en_q, rate_q};
            `BSFD_OFF_SETPOINT: reg_rdata <= set_q;
            `BSFD_OFF_FLOOR: reg_rdata <= floor_q;
            `BSFD_OFF_CEILING: reg_rdata <= ceil_q;
            `BSFD_OFF_SHUTDOWN: reg_rdata <= {5'h0, shd_q};
            `BSFD_OFF_LIMIT: reg_rdata <= lim_q;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

endmodule : bsfd_top

// ---- testbench/bsfd_assertions.sv ----
`timescale 1ns/1ns

module bsfd_chk
(
   input wire logic clk,
   input wire logic rst,
   input wire logic vin_below_fall,
   input wire logic over_temp,
   input wire logic ilim_hit,
   input wire logic ineg_hit,
   input wire logic conv_en,
   input wire logic soft_start,
   input wire logic out_tristate,
   input wire logic pulse_freq_mode,
   input wire logic bypass_on,
   input wire logic pulldown_on,
   input wire logic [1:0] pulldown_sel,
   input wire logic [7:0] dac_code
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   AST_UV_KILL: assert property (
      $rose(vin_below_fall) && conv_en |-> ##[1:5] !conv_en
   ) else $error("converter kept running on low input");
   AST_OT_KILL: assert property (
      $rose(over_temp) && conv_en |-> ##[1:5] !conv_en
   ) else $error("converter kept running when hot");
   AST_SOFT_RUN: assert property (
      soft_start |-> conv_en
   ) else $error("soft start without converter running");
   AST_PD_OPEN: assert property (
      pulldown_sel == 2'h0 && $past(pulldown_sel) == 2'h0 |-> !pulldown_on
   ) else $error("pulldown on with open selection");
   AST_PD_TIME: assert property (
      $fell(conv_en) && !ilim_hit && pulldown_sel != 2'h0
      |-> ##[190:215] pulldown_on
   ) else $error("pulldown late after disable");
   AST_KILL_DEFAULTS: assert property (
      $fell(conv_en) && (vin_below_fall || over_temp)
      |-> ##[0:2] (pulse_freq_mode && !bypass_on)
   ) else $error("mode flags not restored on shutdown");
   AST_CODE_MAX: assert property (
      dac_code <= 8'hb4
   ) else $error("dac code above top of range");
   AST_CODE_STEP: assert property (
      conv_en && $past(conv_en) |-> dac_code <= $past(dac_code) + 8'h01
   ) else $error("dac code rose by more than one step");
   AST_TRI_IDLE: assert property (
      !conv_en && !$past(conv_en) |-> out_tristate
   ) else $error("output driven while disabled");
   AST_NEG_TRI: assert property (
      (conv_en && !pulse_freq_mode && ineg_hit) [*4] |-> ##[0:2] out_tristate
   ) else $error("no tristate on reverse current");
endmodule : bsfd_chk

bind bsfd_top bsfd_chk u_chk (.clk(clk), .rst(rst),
   .vin_below_fall(vin_below_fall), .over_temp(over_temp),
   .ilim_hit(ilim_hit), .ineg_hit(ineg_hit), .conv_en(conv_en),
   .soft_start(soft_start), .out_tristate(out_tristate),
   .pulse_freq_mode(pulse_freq_mode), .bypass_on(bypass_on),
   .pulldown_on(pulldown_on), .pulldown_sel(pulldown_sel),
   .dac_code(dac_code));

// ---- testbench/bsfd_host.sv ----
`timescale 1ns/1ns

module bsfd_host
(
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_we,
   output logic reg_re
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_we = 1'b0;
      reg_re = 1'b0;
   end

   // Released lines carry the inverse of the last value, so a design that
   // samples them outside a strobe picks up garbage rather than a lucky copy.
   task automatic xfer(input logic we, input logic [7:0] a,
                       input logic [7:0] d);
      @(posedge clk);
      reg_we <= we;
      reg_re <= !we;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
      reg_re <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : xfer
endmodule : bsfd_host

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns

module tb_top;
   logic clk, rst, reg_we, reg_re, rd_pend, rnd_on;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, dac_code;
   logic vin_above_rise, vin_below_fall, over_temp, vout_below_half;
   logic ilim_hit, ineg_hit, vout_above_target, vin_near_vout;
   logic load_below_light, load_above_heavy, conv_en, soft_start;
   logic out_tristate, pulse_freq_mode, bypass_on, pulldown_on;
   logic [1:0] pulldown_sel;
   logic [3:0] light_limit_code, fixed_limit_code;
   logic [7:0] exp_q[$];
   integer seed = 32'h95835ac7;
   int n_mismatch = 0;
   int checks = 0;
   int cyc = 0;

   // Identity values are arbitrary.
   bsfd_top #(.ILIM_CYC(20), .RESTART_CYC(30), .PRODUCT_ID(4'h9),
      .SILICON_REV(4'h3)) uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .reg_rdata(reg_rdata), .vin_above_rise(vin_above_rise),
      .vin_below_fall(vin_below_fall), .over_temp(over_temp),
      .vout_below_half(vout_below_half), .ilim_hit(ilim_hit),
      .ineg_hit(ineg_hit), .vout_above_target(vout_above_target),
      .vin_near_vout(vin_near_vout), .load_below_light(load_below_light),
      .load_above_heavy(load_above_heavy), .conv_en(conv_en),
      .soft_start(soft_start), .out_tristate(out_tristate),
      .pulse_freq_mode(pulse_freq_mode), .bypass_on(bypass_on),
      .pulldown_on(pulldown_on), .pulldown_sel(pulldown_sel),
      .dac_code(dac_code), .light_limit_code(light_limit_code),
      .fixed_limit_code(fixed_limit_code));

   bsfd_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re));

   task automatic print_verdict;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.xfer(1'b0, a, 8'h00);
   endtask : rd

   function automatic logic pick(input int s);
      return (s == 0) ? conv_en : soft_start;
   endfunction : pick

   task automatic wait_lvl(input int s, input logic v, input int lim);
      int n;
      n = 0;
      while (pick(s) !== v && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      chk8({7'h00, pick(s)}, {7'h00, v});
   endtask : wait_lvl

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      rd_pend <= reg_re;
      cyc++;
      if (cyc == 60000)
      begin
         n_mismatch++;
         print_verdict();
      end
      if (rnd_on)
      begin
         {vin_near_vout, load_above_heavy, load_below_light} <=
            3'($random(seed));
      end
   end

   always @(negedge clk)
   begin
      if (rd_pend === 1'b1)
      begin
         chk8(reg_rdata, exp_q.pop_front());
      end
   end

   initial
   begin
      {rst, rnd_on} = 2'b10;
      {vin_above_rise, vin_below_fall, over_temp, vout_below_half} = 4'h0;
      {ilim_hit, ineg_hit, vout_above_target, vin_near_vout} = 4'h0;
      {load_below_light, load_above_heavy} = 2'b00;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(8'h07, 8'h01);
      rd(8'h0c, 8'h00);
      wr(8'h00, 8'hff);
      rd(8'h00, 8'h93);
      wr(8'h03, 8'h80);
      repeat (2) @(posedge clk);
      rd(8'h03, 8'h00);
      rd(8'h01, 8'h08);
      rd(8'h01, 8'h00);
      vin_above_rise <= 1'b1;
      repeat (4) @(posedge clk);
      wr(8'h04, 8'h05);
      wr(8'h03, 8'h80);
      wait_lvl(0, 1'b1, 10);
      wait_lvl(1, 1'b0, 2000);
      chk8(dac_code, 8'h05);
      vout_above_target <= 1'b1;
      repeat (5) @(posedge clk);
      chk8({7'h00, out_tristate}, 8'h01);
      vout_above_target <= 1'b0;
      rnd_on <= 1'b1;
      wr(8'h03, 8'h8f);
      repeat (20) @(posedge clk);
      chk8(dac_code, 8'h05);
      wr(8'h04, 8'h08);
      repeat (150) @(posedge clk);
      chk8(dac_code, 8'h06);
      repeat (200) @(posedge clk);
      chk8(dac_code, 8'h08);
      wr(8'h06, 8'h0a);
      wr(8'h04, 8'h20);
      repeat (300) @(posedge clk);
      chk8(dac_code, 8'h0a);
      wr(8'h06, 8'h09);
      repeat (50) @(posedge clk);
      chk8(dac_code, 8'h0a);
      wr(8'h07, 8'h05);
      wr(8'h04, 8'h07);
      repeat (50) @(posedge clk);
      chk8({7'h00, pulldown_on}, 8'h01);
      repeat (300) @(posedge clk);
      chk8(dac_code, 8'h07);
      chk8({7'h00, pulldown_on}, 8'h00);
      wr(8'h05, 8'h08);
      wr(8'h04, 8'h02);
      repeat (150) @(posedge clk);
      chk8(dac_code, 8'h08);
      wr(8'h03, 8'hcf);
      repeat (5) @(posedge clk);
      chk8({7'h00, pulse_freq_mode}, 8'h00);
      ineg_hit <= 1'b1;
      repeat (6) @(posedge clk);
      chk8({7'h00, out_tristate}, 8'h01);
      ineg_hit <= 1'b0;
      vout_below_half <= 1'b1;
      repeat (5) @(posedge clk);
      vout_below_half <= 1'b0;
      rd(8'h01, 8'h02);
      ilim_hit <= 1'b1;
      wait_lvl(0, 1'b0, 100);
      wait_lvl(0, 1'b1, 100);
      wait_lvl(0, 1'b0, 3000);
      // Hold the limit one more edge; the limit trip is already latched when conv_en falls.
      @(posedge clk);
      ilim_hit <= 1'b0;
      rd(8'h01, 8'h03);
      wait_lvl(0, 1'b1, 100);
      wait_lvl(1, 1'b0, 3000);
      rnd_on <= 1'b0;
      vin_near_vout <= 1'b1;
      repeat (5) @(posedge clk);
      chk8({7'h00, bypass_on}, 8'h01);
      vin_below_fall <= 1'b1;
      vin_above_rise <= 1'b0;
      wait_lvl(0, 1'b0, 10);
      rd(8'h03, 8'h4f);
      rd(8'h01, 8'h08);
      rd(8'h02, 8'h18);
      chk8({6'h00, bypass_on, pulse_freq_mode}, 8'h01);
      vin_below_fall <= 1'b0;
      vin_above_rise <= 1'b1;
      repeat (4) @(posedge clk);
      rd(8'h02, 8'h50);
      repeat (250) @(posedge clk);
      wr(8'h03, 8'hcf);
      wait_lvl(0, 1'b1, 10);
      over_temp <= 1'b1;
      wait_lvl(0, 1'b0, 10);
      rd(8'h01, 8'h04);
      rd(8'h02, 8'h14);
      wr(8'h03, 8'hcf);
      rd(8'h03, 8'h4f);
      over_temp <= 1'b0;
      repeat (250) @(posedge clk);
      chk8({7'h00, pulldown_on}, 8'h01);
      wr(8'h08, 8'h3a);
      rd(8'h08, 8'h3a);
      chk8({light_limit_code, fixed_limit_code}, 8'h3a);
      wr(8'h03, 8'h20);
      wr(8'h08, 8'h51);
      rd(8'h08, 8'h3a);
      wr(8'h07, 8'h00);
      repeat (5) @(posedge clk);
      chk8({7'h00, pulldown_on}, 8'h00);
      chk8({6'h00, pulldown_sel}, 8'h00);
      wr(8'h09, 8'ha5);
      rd(8'h08, 8'hff);
      rd(8'h07, 8'h01);
      repeat (3) @(posedge clk);
      print_verdict();
   end
endmodule : tb_top
